/* acqfc_top.v */
// The address map and the AXI4-Lite register port were decided locally.
`include "acqfc_defines.vh"

module acqfc_top #(
    parameter AW        = 4,
    parameter INF_LINES = 8
) (
    input  wire        clk_in,
    input  wire        rst_b_in,
    input  wire [7:0]  s_axi_awaddr_in,
    input  wire        s_axi_awvalid_in,
    output wire        s_axi_awready_out,
    input  wire [31:0] s_axi_wdata_in,
    input  wire [3:0]  s_axi_wstrb_in,
    input  wire        s_axi_wvalid_in,
    output wire        s_axi_wready_out,
    output wire [1:0]  s_axi_bresp_out,
    output wire        s_axi_bvalid_out,
    input  wire        s_axi_bready_in,
    input  wire [7:0]  s_axi_araddr_in,
    input  wire        s_axi_arvalid_in,
    output wire        s_axi_arready_out,
    output wire [31:0] s_axi_rdata_out,
    output wire [1:0]  s_axi_rresp_out,
    output wire        s_axi_rvalid_out,
    input  wire        s_axi_rready_in,
    input  wire [2:0]  line_valid_in,
    input  wire [95:0] line_data_in,
    input  wire [2:0]  line_err_in,
    output wire        acq_active_out,
    output wire        overrun_out
);

    localparam DEPTH = 1 << AW;

    // ----------------------------------------
    // Reset synchroniser
    // ----------------------------------------
    reg rst_s1_r;
    reg rst_s2_r;
    always @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            rst_s1_r <= 1'b0;
            rst_s2_r <= 1'b0;
        end else begin
            rst_s1_r <= 1'b1;
            rst_s2_r <= rst_s1_r;
        end
    end
    wire rst_n = rst_s2_r;

    // ----------------------------------------
    // State
    // ----------------------------------------
    reg        awready_r;
    reg        wready_r;
    reg        bvalid_r;
    reg [1:0]  bresp_r;
    reg        arready_r;
    reg        rvalid_r;
    reg [1:0]  rresp_r;
    reg [31:0] rdata_r;
    reg        aw_hold_r;
    reg        w_hold_r;
    reg [7:0]  awaddr_r;
    reg [31:0] wdata_r;
    reg [3:0]  wstrb_r;
    reg [31:0] arg_r;
    reg [31:0] qsel_r;
    reg [31:0] cmd_word_r;
    reg        cmd_go_r;
    reg [2:0]  err_r;
    reg [15:0] rate_r [0:2];
    reg [15:0] fmt_r  [0:2];
    reg        active_r;
    reg [1:0]  mode_r;
    reg [31:0] target_r;
    reg [31:0] lines_r [0:2];
    reg [AW:0] wp_r [0:2];
    reg [AW:0] rp_r [0:2];
    reg        ovr_r;
    reg [31:0] mem [0:4*DEPTH-1];
    integer    g;

    // ----------------------------------------
    // Helpers
    // ----------------------------------------
    function [31:0] merge;
        input [31:0] old_v;
        input [31:0] new_v;
        input [3:0]  strb;
        integer b;
        begin
            merge = old_v;
            for (b = 0; b < 4; b = b + 1) begin
                if (strb[b]) begin
                    merge[8*b +: 8] = new_v[8*b +: 8];
                end
            end
        end
    endfunction

    // Fixed rate table; codes outside it are refused
    function is_rate;
        input [31:0] code;
        begin
            case (code)
                32'h0000_189C, 32'h0000_189D, 32'h0000_189E, 32'h0000_189F,
                32'h0000_18B6, 32'h0000_18A0, 32'h0000_18A1, 32'h0000_18A3,
                32'h0000_18A4, 32'h0000_18A5, 32'h0000_18A6, 32'h0000_18A7,
                32'h0000_18A9, 32'h0000_18AB, 32'h0000_18AD, 32'h0000_18AF,
                32'h0000_18B0, 32'h0000_18C9: is_rate = 1'b1;
                default: is_rate = 1'b0;
            endcase
        end
    endfunction

    function [AW:0] fill;
        input [1:0] grp;
        begin
            fill = wp_r[grp] - rp_r[grp];
        end
    endfunction

    // Line capacity of the current mode
    function [AW:0] cap;
        input [1:0] mode;
        begin
            if (mode == `ACQFC_MODE_LAST) begin
                cap = {{AW{1'b0}}, 1'b1};
            end else if (mode == `ACQFC_MODE_INF) begin
                cap = INF_LINES[AW:0];
            end else begin
                cap = DEPTH[AW:0];
            end
        end
    endfunction

    // ----------------------------------------
    // Command decode
    // ----------------------------------------
    wire [3:0]  cmd_op    = cmd_word_r[`ACQFC_OP_MSB:0];
    wire        cmd_given = cmd_word_r[`ACQFC_GIVEN_BIT];
    wire [1:0]  cmd_grp   = cmd_given ? cmd_word_r[`ACQFC_GRP_LSB +: 2] : 2'd0;
    wire        do_rate   = cmd_go_r && (cmd_op == `ACQFC_OP_SET_RATE);
    wire        do_start  = cmd_go_r && (cmd_op == `ACQFC_OP_START);
    wire        do_halt   = cmd_go_r && (cmd_op == `ACQFC_OP_HALT);
    wire        do_move   = cmd_go_r && (cmd_op == `ACQFC_OP_MOVE_PTR);
    wire        do_fmt    = cmd_go_r && (cmd_op == `ACQFC_OP_SET_FMT);
    wire        bad_op    = cmd_go_r && ((cmd_op == 4'h0) || (cmd_op > `ACQFC_OP_SET_FMT));
    wire        bad_grp   = (do_rate || do_fmt) && (cmd_grp == 2'd3);
    wire        bad_rate  = do_rate && !is_rate(arg_r);
    wire        bad_fmt   = do_fmt && (arg_r != {16'h0000, `ACQFC_FMT_FLOAT});
    wire        bad_start = do_start && arg_r[31] && (arg_r != 32'hFFFF_FFFF);
    wire [1:0]  q_grp     = qsel_r[2] ? qsel_r[1:0] : 2'd0;
    wire        q_ok      = (q_grp != 2'd3);

    // ----------------------------------------
    // Configuration and error flags
    // ----------------------------------------
    always @(posedge clk_in or negedge rst_n) begin
        if (!rst_n) begin
            for (g = 0; g < 3; g = g + 1) begin
                rate_r[g] <= `ACQFC_RATE_DEFAULT;
                fmt_r[g]  <= `ACQFC_FMT_FLOAT;
            end
            err_r <= 3'd0;
        end else begin
            if (do_rate && !bad_rate && !bad_grp) begin
                rate_r[cmd_grp] <= arg_r[15:0];
            end
            if (do_fmt && !bad_fmt && !bad_grp) begin
                for (g = 0; g < 3; g = g + 1) begin
                    if (!cmd_given || (cmd_grp == g[1:0])) begin
                        fmt_r[g] <= arg_r[15:0];
                    end
                end
            end
            // Trigger settings have no storage at all
            // Set wins over a software clear in the same cycle
            err_r <= (err_r & ~((aw_hold_r && w_hold_r && !bvalid_r &&
                                 awaddr_r == `ACQFC_ERR_OFS) ? wdata_r[2:0] : 3'd0))
                     | {bad_op || bad_grp || bad_start, bad_fmt, bad_rate};
        end
    end

    // ----------------------------------------
    // Acquisition control
    // ----------------------------------------
    reg [2:0] take;
    reg [2:0] drop;
    reg       all_done;
    always @* begin
        take     = 3'd0;
        drop     = 3'd0;
        all_done = 1'b1;
        for (g = 0; g < 3; g = g + 1) begin
            if (active_r && line_valid_in[g] &&
                ((mode_r != `ACQFC_MODE_FIN) || (lines_r[g] < target_r))) begin
                // Latest-line mode overwrites instead of refusing
                if ((fill(g[1:0]) >= cap(mode_r)) && (mode_r != `ACQFC_MODE_LAST)) begin
                    drop[g] = 1'b1;
                end else begin
                    take[g] = 1'b1;
                end
            end
            if (lines_r[g] < target_r) begin
                all_done = 1'b0;
            end
        end
    end

    always @(posedge clk_in or negedge rst_n) begin
        if (!rst_n) begin
            active_r <= 1'b0;
            mode_r   <= `ACQFC_MODE_INF;
            target_r <= 32'd0;
            ovr_r    <= 1'b0;
            for (g = 0; g < 3; g = g + 1) begin
                lines_r[g] <= 32'd0;
            end
        end else begin
            if (do_start && !bad_start) begin
                active_r <= 1'b1;
                target_r <= arg_r;
                if (arg_r == 32'hFFFF_FFFF) begin
                    mode_r <= `ACQFC_MODE_LAST;
                end else if (arg_r == 32'd0) begin
                    mode_r <= `ACQFC_MODE_INF;
                end else begin
                    mode_r <= `ACQFC_MODE_FIN;
                end
                for (g = 0; g < 3; g = g + 1) begin
                    lines_r[g] <= 32'd0;
                end
            end else begin
                if (do_halt) begin
                    active_r <= 1'b0;
                end else if (active_r && (mode_r == `ACQFC_MODE_FIN) && all_done) begin
                    active_r <= 1'b0;
                end
                for (g = 0; g < 3; g = g + 1) begin
                    if (take[g] || drop[g]) begin
                        lines_r[g] <= lines_r[g] + 32'd1;
                    end
                end
            end
            // Overrun survives a start that meets a new overrun
            if (|drop) begin
                ovr_r <= 1'b1;
            end else if (do_start && !bad_start) begin
                ovr_r <= 1'b0;
            end
        end
    end

    // ----------------------------------------
    // FIFO pointers and storage
    // ----------------------------------------
    wire data_rd = s_axi_arvalid_in && arready_r && (s_axi_araddr_in == `ACQFC_DATA_OFS);
    wire pop     = data_rd && q_ok && (fill(q_grp) != 0);

    always @(posedge clk_in) begin
        for (g = 0; g < 3; g = g + 1) begin
            if (take[g]) begin
                mem[{g[1:0], wp_r[g][AW-1:0]}] <= line_err_in[g] ? `ACQFC_ERR_VALUE :
                                                  line_data_in[32*g +: 32];
            end
        end
    end

    always @(posedge clk_in or negedge rst_n) begin
        if (!rst_n) begin
            for (g = 0; g < 3; g = g + 1) begin
                wp_r[g] <= {(AW+1){1'b0}};
                rp_r[g] <= {(AW+1){1'b0}};
            end
        end else begin
            for (g = 0; g < 3; g = g + 1) begin
                if (do_start && !bad_start) begin
                    wp_r[g] <= {(AW+1){1'b0}};
                    rp_r[g] <= {(AW+1){1'b0}};
                end else begin
                    if (take[g]) begin
                        wp_r[g] <= wp_r[g] + 1'b1;
                    end
                    // No range check: host keeps the offset legal
                    if (do_move && (cmd_grp == g[1:0])) begin
                        rp_r[g] <= rp_r[g] + arg_r[AW:0];
                    end else if (take[g] && (mode_r == `ACQFC_MODE_LAST) &&
                                 (fill(g[1:0]) != 0)) begin
                        rp_r[g] <= rp_r[g] + 1'b1;
                    end else if (pop && (q_grp == g[1:0])) begin
                        rp_r[g] <= rp_r[g] + 1'b1;
                    end
                end
            end
        end
    end

    // ----------------------------------------
    // Read decode
    // ----------------------------------------
    reg [31:0] rd_mux;
    reg        rd_err;
    always @* begin
        rd_mux = 32'd0;
        rd_err = 1'b0;
        if (s_axi_araddr_in == `ACQFC_CMD_OFS) begin
            rd_mux = cmd_word_r;
        end else if (s_axi_araddr_in == `ACQFC_ARG_OFS) begin
            rd_mux = arg_r;
        end else if (s_axi_araddr_in == `ACQFC_QSEL_OFS) begin
            rd_mux = qsel_r;
        end else if (s_axi_araddr_in == `ACQFC_RATE_Q_OFS) begin
            rd_mux = q_ok ? {16'h0000, rate_r[q_grp]} : 32'd0;
        end else if (s_axi_araddr_in == `ACQFC_TRIG_MODE_OFS) begin
            rd_mux = {16'h0000, `ACQFC_TRIG_STANDALONE};
        end else if (s_axi_araddr_in == `ACQFC_TRIG_SLOT_OFS) begin
            rd_mux = 32'd0;
        end else if (s_axi_araddr_in == `ACQFC_TRIG_RSLOT_OFS) begin
            rd_mux = 32'd0;
        end else if (s_axi_araddr_in == `ACQFC_ACQ_LINES_OFS) begin
            rd_mux = q_ok ? {{(31-AW){1'b0}}, fill(q_grp)} : 32'd0;
        end else if (s_axi_araddr_in == `ACQFC_ACQ_STATE_OFS) begin
            rd_mux = active_r ? `ACQFC_STATE_ACTIVE : `ACQFC_STATE_DONE;
        end else if (s_axi_araddr_in == `ACQFC_ACQ_STAT_OFS) begin
            rd_mux = {31'd0, ovr_r};
        end else if (s_axi_araddr_in == `ACQFC_PTR_LINES_OFS) begin
            rd_mux = q_ok ? {{(31-AW){1'b0}}, fill(q_grp)} : 32'd0;
        end else if (s_axi_araddr_in == `ACQFC_REC_STATE_OFS) begin
            rd_mux = {31'd0, active_r};
        end else if (s_axi_araddr_in == `ACQFC_FMT_Q_OFS) begin
            rd_mux = q_ok ? {16'h0000, fmt_r[q_grp]} : 32'd0;
        end else if (s_axi_araddr_in == `ACQFC_ERR_OFS) begin
            rd_mux = {29'd0, err_r};
        end else if (s_axi_araddr_in == `ACQFC_DATA_OFS) begin
            // Halt does not end output: data is read until the FIFO is empty
            rd_mux = pop ? mem[{q_grp, rp_r[q_grp][AW-1:0]}] : 32'd0;
        end else begin
            rd_err = 1'b1;
        end
    end

    // ----------------------------------------
    // AXI4-Lite slave
    // ----------------------------------------
    wire wr_commit = aw_hold_r && w_hold_r && !bvalid_r;
    wire wr_known  = (awaddr_r == `ACQFC_CMD_OFS) || (awaddr_r == `ACQFC_ARG_OFS) ||
                     (awaddr_r == `ACQFC_QSEL_OFS) || (awaddr_r == `ACQFC_ERR_OFS);

    always @(posedge clk_in or negedge rst_n) begin
        if (!rst_n) begin
            awready_r  <= 1'b0;
            wready_r   <= 1'b0;
            bvalid_r   <= 1'b0;
            bresp_r    <= `ACQFC_RESP_OKAY;
            arready_r  <= 1'b0;
            rvalid_r   <= 1'b0;
            rresp_r    <= `ACQFC_RESP_OKAY;
            rdata_r    <= 32'd0;
            aw_hold_r  <= 1'b0;
            w_hold_r   <= 1'b0;
            awaddr_r   <= 8'd0;
            wdata_r    <= 32'd0;
            wstrb_r    <= 4'd0;
            arg_r      <= 32'd0;
            qsel_r     <= 32'd0;
            cmd_word_r <= 32'd0;
            cmd_go_r   <= 1'b0;
        end else begin
            cmd_go_r <= 1'b0;
            if (!aw_hold_r && !awready_r && !bvalid_r) begin
                awready_r <= 1'b1;
            end
            if (!w_hold_r && !wready_r && !bvalid_r) begin
                wready_r <= 1'b1;
            end
            if (s_axi_awvalid_in && awready_r) begin
                aw_hold_r <= 1'b1;
                awready_r <= 1'b0;
                awaddr_r  <= {s_axi_awaddr_in[7:2], 2'b00};
            end
            if (s_axi_wvalid_in && wready_r) begin
                w_hold_r <= 1'b1;
                wready_r <= 1'b0;
                wdata_r  <= s_axi_wdata_in;
                wstrb_r  <= s_axi_wstrb_in;
            end
            if (wr_commit) begin
                aw_hold_r <= 1'b0;
                w_hold_r  <= 1'b0;
                bvalid_r  <= 1'b1;
                bresp_r   <= wr_known ? `ACQFC_RESP_OKAY : `ACQFC_RESP_SLVERR;
                if (awaddr_r == `ACQFC_CMD_OFS) begin
                    cmd_word_r <= merge(cmd_word_r, wdata_r, wstrb_r);
                    cmd_go_r   <= 1'b1;
                end else if (awaddr_r == `ACQFC_ARG_OFS) begin
                    arg_r <= merge(arg_r, wdata_r, wstrb_r);
                end else if (awaddr_r == `ACQFC_QSEL_OFS) begin
                    qsel_r <= merge(qsel_r, wdata_r, wstrb_r) & 32'h0000_0007;
                end
            end
            if (bvalid_r && s_axi_bready_in) begin
                bvalid_r <= 1'b0;
            end
            if (!rvalid_r && !arready_r) begin
                arready_r <= 1'b1;
            end
            if (s_axi_arvalid_in && arready_r) begin
                arready_r <= 1'b0;
                rvalid_r  <= 1'b1;
                rdata_r   <= rd_mux;
                rresp_r   <= rd_err ? `ACQFC_RESP_SLVERR : `ACQFC_RESP_OKAY;
            end
            if (rvalid_r && s_axi_rready_in) begin
                rvalid_r <= 1'b0;
            end
        end
    end

    assign s_axi_awready_out = awready_r;
    assign s_axi_wready_out  = wready_r;
    assign s_axi_bresp_out   = bresp_r;
    assign s_axi_bvalid_out  = bvalid_r;
    assign s_axi_arready_out = arready_r;
    assign s_axi_rdata_out   = rdata_r;
    assign s_axi_rresp_out   = rresp_r;
    assign s_axi_rvalid_out  = rvalid_r;
    assign acq_active_out    = active_r;
    assign overrun_out       = ovr_r;

endmodule // acqfc_top

/* acqfc_defines.vh */
// Operation
// - One sample rate per group, three groups
// - Rate command without group sets group 0
// - Rate codes 6300..6345, default 6317
// - Rate query returns group rate, default 0
// - Trigger setting accepted, arguments ignored
// - Trigger query reports 6713, slots zero
// - Positive count acquires N lines, then stops
// - Count zero runs until halted, small FIFO
// - Count -1 keeps only newest line
// - Start command clears overrun bit
// - State query reports unread FIFO lines
// - State 2 while active, 3 when ended
// - Status bit 0 is overrun, sticky
// - Halt ends acquisition, not output
// - Pointer move by signed offset, group 3 async
// - Pointer move without group uses group 0
// - Pointer query reports readable lines
// - Pointer query reports recording, default 0
// - Only format 1257 accepted
// - Bad sample replaced by 2e20
// - Format without group sets all groups
// - Each group has its own FIFO
`ifndef ACQFC_DEFINES_VH
`define ACQFC_DEFINES_VH

// ----------------------------------------
// Register byte offsets
// ----------------------------------------
`define ACQFC_CMD_OFS        8'h00
`define ACQFC_ARG_OFS        8'h04
`define ACQFC_QSEL_OFS       8'h08
`define ACQFC_RATE_Q_OFS     8'h0C
`define ACQFC_TRIG_MODE_OFS  8'h10
`define ACQFC_TRIG_SLOT_OFS  8'h14
`define ACQFC_TRIG_RSLOT_OFS 8'h18
`define ACQFC_ACQ_LINES_OFS  8'h1C
`define ACQFC_ACQ_STATE_OFS  8'h20
`define ACQFC_ACQ_STAT_OFS   8'h24
`define ACQFC_PTR_LINES_OFS  8'h28
`define ACQFC_REC_STATE_OFS  8'h2C
`define ACQFC_FMT_Q_OFS      8'h30
`define ACQFC_ERR_OFS        8'h34
`define ACQFC_DATA_OFS       8'h38

// ----------------------------------------
// Command word fields and opcodes
// ----------------------------------------
`define ACQFC_OP_MSB         3
`define ACQFC_GRP_LSB        4
`define ACQFC_GIVEN_BIT      6
`define ACQFC_OP_SET_RATE    4'h1
`define ACQFC_OP_SET_TRIG    4'h2
`define ACQFC_OP_START       4'h3
`define ACQFC_OP_HALT        4'h4
`define ACQFC_OP_MOVE_PTR    4'h5
`define ACQFC_OP_SET_FMT     4'h6

// ----------------------------------------
// Codes and reset values
// ----------------------------------------
`define ACQFC_RATE_DEFAULT   16'h18AD
`define ACQFC_TRIG_STANDALONE 16'h1A39
`define ACQFC_FMT_FLOAT      16'h04E9
`define ACQFC_ERR_VALUE      32'h612D_78EC
`define ACQFC_STATE_ACTIVE   32'h0000_0002
`define ACQFC_STATE_DONE     32'h0000_0003
`define ACQFC_MODE_FIN       2'h0
`define ACQFC_MODE_INF       2'h1
`define ACQFC_MODE_LAST      2'h2
`define ACQFC_RESP_OKAY      2'h0
`define ACQFC_RESP_SLVERR    2'h2

`endif

/* acqfc_top_checker.sv */
module acqfc_top_checker #(
    parameter AW        = 4,
    parameter INF_LINES = 8
) (
    input wire logic        clk_in,
    input wire logic        rst_b_in,
    input wire logic        s_axi_awvalid_in,
    input wire logic        s_axi_awready_out,
    input wire logic [1:0]  s_axi_bresp_out,
    input wire logic        s_axi_bvalid_out,
    input wire logic        s_axi_bready_in,
    input wire logic [7:0]  s_axi_araddr_in,
    input wire logic        s_axi_arvalid_in,
    input wire logic        s_axi_arready_out,
    input wire logic [31:0] s_axi_rdata_out,
    input wire logic [1:0]  s_axi_rresp_out,
    input wire logic        s_axi_rvalid_out,
    input wire logic        s_axi_rready_in,
    input wire logic [2:0]  line_valid_in,
    input wire logic        overrun_out
);
    // ----------------------------------------
    // Bus and status properties
    // ----------------------------------------
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (!rst_b_in);

    a_b_hold: assert property (s_axi_bvalid_out && !s_axi_bready_in |=> s_axi_bvalid_out && $stable(s_axi_bresp_out))
        else $error("write response dropped early");
    a_r_hold: assert property (s_axi_rvalid_out && !s_axi_rready_in |=> s_axi_rvalid_out && $stable(s_axi_rdata_out))
        else $error("read data dropped early");
    a_read_answer: assert property (s_axi_arvalid_in && s_axi_arready_out |=> s_axi_rvalid_out)
        else $error("read answer late");
    a_ar_blocked: assert property (s_axi_rvalid_out |-> !s_axi_arready_out)
        else $error("second read accepted");
    a_aw_drop: assert property (s_axi_awvalid_in && s_axi_awready_out |=> !s_axi_awready_out)
        else $error("write address ready held");
    a_trig_mode: assert property (s_axi_arvalid_in && s_axi_arready_out && s_axi_araddr_in == 8'h10
        |=> s_axi_rdata_out == 32'h0000_1A39) else $error("trigger mode read wrong");
    a_trig_slots: assert property (s_axi_arvalid_in && s_axi_arready_out
        && (s_axi_araddr_in == 8'h14 || s_axi_araddr_in == 8'h18) |=> s_axi_rdata_out == 32'h0)
        else $error("trigger slot not zero");
    a_unmapped_rd: assert property (s_axi_arvalid_in && s_axi_arready_out && s_axi_araddr_in == 8'h3C
        |=> s_axi_rresp_out == 2'h2 && s_axi_rdata_out == 32'h0) else $error("unmapped read not refused");
    a_ovr_cause: assert property ($rose(overrun_out) |->
        ($past(line_valid_in) != 3'h0) || ($past(line_valid_in, 2) != 3'h0)) else $error("overrun without a line");
endmodule // acqfc_top_checker

bind acqfc_top acqfc_top_checker #(.AW(AW), .INF_LINES(INF_LINES)) acqfc_top_checker_inst (.*);

/* acqfc_line_src.sv */
module acqfc_line_src (
    input  wire logic        clk_in,
    output logic      [2:0]  line_valid_out,
    output logic      [95:0] line_data_out,
    output logic      [2:0]  line_err_out
);
    timeunit 1ns;
    timeprecision 100ps;

    initial begin
        line_valid_out = 3'h0;
        line_data_out = 96'h0;
        line_err_out = 3'h0;
    end

    // ----------------------------------------
    // One line to every group at once
    // ----------------------------------------
    // Groups get distinct data so a mixed-up FIFO shows
    task automatic send(input logic [31:0] d, input logic [2:0] e);
        @(posedge clk_in);
        line_valid_out <= 3'h7;
        line_data_out <= {d + 32'h0000_0200, d + 32'h0000_0100, d};
        line_err_out <= e;
        @(posedge clk_in);
        line_valid_out <= 3'h0;
        line_data_out <= ~line_data_out;
        line_err_out <= 3'h0;
    endtask
endmodule // acqfc_line_src

/* acqfc_top_tb.sv */
module acqfc_top_tb;
    timeunit 1ns;
    timeprecision 100ps;

    logic        clk_in, rst_b_in, awvalid, wvalid, bready, arvalid, rready;
    logic        awready, wready, bvalid, arready, rvalid, acq_active, overrun;
    logic [7:0]  awaddr, araddr;
    logic [31:0] wdata, rdata, v;
    logic [1:0]  bresp, rresp, r;
    logic [2:0]  lv, le;
    logic [95:0] ld;
    int          num_errors = 0;
    int          checked = 0;
    int          cycles = 0;

    acqfc_top #(.AW(3), .INF_LINES(4)) acqfc_top_inst (
        .clk_in(clk_in), .rst_b_in(rst_b_in), .s_axi_awaddr_in(awaddr), .s_axi_awvalid_in(awvalid),
        .s_axi_awready_out(awready), .s_axi_wdata_in(wdata), .s_axi_wstrb_in(4'hF), .s_axi_wvalid_in(wvalid),
        .s_axi_wready_out(wready), .s_axi_bresp_out(bresp), .s_axi_bvalid_out(bvalid), .s_axi_bready_in(bready),
        .s_axi_araddr_in(araddr), .s_axi_arvalid_in(arvalid), .s_axi_arready_out(arready),
        .s_axi_rdata_out(rdata), .s_axi_rresp_out(rresp), .s_axi_rvalid_out(rvalid), .s_axi_rready_in(rready),
        .line_valid_in(lv), .line_data_in(ld), .line_err_in(le), .acq_active_out(acq_active),
        .overrun_out(overrun));
    acqfc_line_src acqfc_line_src_inst (.clk_in(clk_in), .line_valid_out(lv), .line_data_out(ld), .line_err_out(le));

    initial begin
        clk_in = 1'b0;
        forever #10 clk_in = ~clk_in;
    end

    // ----------------------------------------
    // Bus tasks
    // ----------------------------------------
    task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
        checked++;
        if (s !== e) begin
            num_errors++;
            $display("ERROR %s expected %h seen %h", n, e, s);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] rs);
        bit ta, tw;
        ta = 0;
        tw = 0;
        @(posedge clk_in);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        while (!(ta && tw)) begin
            @(posedge clk_in);
            if (awvalid && awready) begin
                ta = 1;
                awvalid <= 1'b0;
            end
            if (wvalid && wready) begin
                tw = 1;
                wvalid <= 1'b0;
            end
        end
        do @(posedge clk_in); while (bvalid !== 1'b1);
        rs = bresp;
        bready <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] rs);
        @(posedge clk_in);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do @(posedge clk_in); while (arready !== 1'b1);
        arvalid <= 1'b0;
        do @(posedge clk_in); while (rvalid !== 1'b1);
        d = rdata;
        rs = rresp;
        rready <= 1'b0;
    endtask

    // Argument goes first: the command word triggers execution
    task automatic cmd(input logic [3:0] op, input logic [1:0] g, input logic s, input logic [31:0] a);
        wr(8'h04, a, r);
        wr(8'h00, {25'h0, s, g, op}, r);
        repeat (3) @(posedge clk_in);
    endtask

    task automatic q(input logic [2:0] s, input logic [7:0] a, input logic [31:0] e);
        wr(8'h08, {29'h0, s}, r);
        rd(a, v, r);
        chk($sformatf("reg_%h", a), v, e);
    endtask

    task automatic stop_test;
        if (num_errors == 0 && checked > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    always @(posedge clk_in) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            num_errors++;
            stop_test();
        end
    end

    // ----------------------------------------
    // Test sequence
    // ----------------------------------------
    initial begin
        rst_b_in = 1'b0;
        {awvalid, wvalid, bready, arvalid, rready} = 5'h0;
        awaddr = 8'h00;
        araddr = 8'h00;
        wdata = 32'h0;
        repeat (4) @(posedge clk_in);
        rst_b_in <= 1'b1;
        q(3'h0, 8'h0C, 32'h0000_18AD);
        q(3'h0, 8'h10, 32'h0000_1A39);
        q(3'h0, 8'h14, 32'h0);
        q(3'h0, 8'h18, 32'h0);
        q(3'h0, 8'h20, 32'h3);
        q(3'h0, 8'h30, 32'h0000_04E9);
        rd(8'h3C, v, r);
        chk("unmapped_rresp", {30'h0, r}, 32'h2);
        wr(8'h0C, 32'h1, r);
        chk("readonly_bresp", {30'h0, r}, 32'h2);
        cmd(4'h1, 2'h0, 1'b0, 32'h0000_18C9);
        cmd(4'h1, 2'h2, 1'b1, 32'h0000_189C);
        q(3'h0, 8'h0C, 32'h0000_18C9);
        q(3'h5, 8'h0C, 32'h0000_18AD);
        q(3'h6, 8'h0C, 32'h0000_189C);
        cmd(4'h2, 2'h3, 1'b1, 32'h0000_1234);
        q(3'h0, 8'h10, 32'h0000_1A39);
        cmd(4'h6, 2'h0, 1'b0, 32'h0000_04EA);
        q(3'h5, 8'h30, 32'h0000_04E9);
        q(3'h0, 8'h34, 32'h2);
        cmd(4'h6, 2'h0, 1'b0, 32'h0000_04E9);
        q(3'h6, 8'h30, 32'h0000_04E9);
        // Finite run of two lines, bad sample on group 1
        cmd(4'h3, 2'h0, 1'b0, 32'h2);
        q(3'h0, 8'h20, 32'h2);
        q(3'h0, 8'h2C, 32'h1);
        acqfc_line_src_inst.send(32'h0000_0011, 3'h2);
        acqfc_line_src_inst.send(32'h0000_0022, 3'h0);
        repeat (4) @(posedge clk_in);
        chk("acq_active", {31'h0, acq_active}, 32'h0);
        q(3'h0, 8'h20, 32'h3);
        q(3'h0, 8'h1C, 32'h2);
        q(3'h0, 8'h2C, 32'h0);
        q(3'h5, 8'h38, 32'h612D_78EC);
        q(3'h0, 8'h28, 32'h2);
        cmd(4'h5, 2'h0, 1'b0, 32'h1);
        q(3'h0, 8'h28, 32'h1);
        q(3'h4, 8'h38, 32'h22);
        // Endless run overflowing the small FIFO, then halted
        cmd(4'h3, 2'h0, 1'b0, 32'h0);
        repeat (5) acqfc_line_src_inst.send(32'h0000_0040, 3'h0);
        q(3'h0, 8'h1C, 32'h4);
        q(3'h0, 8'h24, 32'h1);
        chk("overrun", {31'h0, overrun}, 32'h1);
        cmd(4'h4, 2'h0, 1'b0, 32'h0);
        q(3'h0, 8'h20, 32'h3);
        q(3'h0, 8'h24, 32'h1);
        // Newest-line mode
        cmd(4'h3, 2'h0, 1'b0, 32'hFFFF_FFFF);
        q(3'h0, 8'h24, 32'h0);
        for (int i = 1; i < 4; i++) acqfc_line_src_inst.send(32'h0000_0030 + i, 3'h0);
        q(3'h6, 8'h1C, 32'h1);
        q(3'h6, 8'h38, 32'h0000_0233);
        q(3'h0, 8'h24, 32'h0);
        cmd(4'h4, 2'h0, 1'b0, 32'h0);
        stop_test();
    end
endmodule // acqfc_top_tb
